// *** rtl/useq_consts.svh ***
// Constants for the microprogram address sequencer slice
`ifndef USEQ_CONSTS_SVH
`define USEQ_CONSTS_SVH
`define USEQ_WIDTH 4
`define USEQ_DEPTH 4
`define USEQ_SEL_COUNTER 2'h0
`define USEQ_SEL_HOLD 2'h1
`define USEQ_SEL_STACK 2'h2
`define USEQ_SEL_BRANCH 2'h3
`define USEQ_RESET_VALUE 4'h0
`endif

// *** rtl/useq_pkg.sv ***
// Types for the microprogram address sequencer slice
package useq_pkg;
    typedef enum logic [1:0] {
        SRC_COUNTER = 2'h0,
        SRC_HOLD = 2'h1,
        SRC_STACK = 2'h2,
        SRC_BRANCH = 2'h3
    } source_select_t;

    typedef struct packed {
        source_select_t source_select;
        logic stack_cmd_enable_n;
        logic push_pop_dir;
    } seq_cmd_t;
endpackage : useq_pkg

// *** rtl/useq_incr.sv ***
// Ripple incrementer with carry in and carry out
`timescale 1ns/1ps
module useq_incr #(
    parameter int WIDTH = 4
) (
    input wire logic [WIDTH-1:0] i_value,
    input wire logic i_carry,
    output logic [WIDTH-1:0] o_sum,
    output logic o_carry
);
    wire [WIDTH:0] full_sum;

    assign full_sum = {1'b0, i_value} + {{WIDTH{1'b0}}, i_carry};
    assign o_sum = full_sum[WIDTH-1:0];
    assign o_carry = full_sum[WIDTH];
endmodule : useq_incr

// *** rtl/useq_sequencer.sv ***
// Microprogram address sequencer slice: source mux, counter, hold latch, stack
`timescale 1ns/1ps
`include "useq_consts.svh"
module useq_sequencer #(
    parameter int WIDTH = `USEQ_WIDTH,
    parameter int DEPTH = `USEQ_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire useq_pkg::seq_cmd_t i_cmd,
    input wire logic i_hold_latch_load_en_n,
    input wire logic [WIDTH-1:0] i_hold_latch_inputs,
    input wire logic [WIDTH-1:0] i_branch_inputs,
    input wire logic [WIDTH-1:0] i_output_force_one,
    input wire logic i_output_clear_n,
    input wire logic i_output_drive_en_n,
    input wire logic i_incr_carry_in,
    output logic [WIDTH-1:0] o_next_addr_bus,
    output logic [WIDTH-1:0] o_next_addr_bus_oe,
    output logic o_incr_carry_out
);
    localparam int PW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Reset is an addition for simulation; the slice itself has none
    logic [WIDTH-1:0] sequence_counter;
    logic [WIDTH-1:0] branch_hold_latch;
    logic [WIDTH-1:0] stack_words [DEPTH];
    logic [PW-1:0] stack_index;

    // ----------------------------------------------------------------
    // Address selection and output control
    // ----------------------------------------------------------------
    wire [WIDTH-1:0] stack_top;
    wire [WIDTH-1:0] selected_addr;
    wire [WIDTH-1:0] shaped_addr;
    wire [WIDTH-1:0] next_counter;
    wire do_push;
    wire do_pop;
    wire [PW-1:0] next_index;

    assign stack_top = stack_words[stack_index];
    // Combinational mux: address valid within the cycle the select is applied
    assign selected_addr =
        (i_cmd.source_select == useq_pkg::SRC_COUNTER) ? sequence_counter :
        (i_cmd.source_select == useq_pkg::SRC_HOLD) ? branch_hold_latch :
        (i_cmd.source_select == useq_pkg::SRC_STACK) ? stack_top :
        i_branch_inputs;
    // Clear beats force-one; drive enable beats both
    assign shaped_addr = i_output_clear_n ? (selected_addr | i_output_force_one)
                                          : {WIDTH{1'b0}};
    assign o_next_addr_bus = shaped_addr;
    assign o_next_addr_bus_oe = {WIDTH{~i_output_drive_en_n}};

    // Counter takes the shaped bus value, so clear and force-one also steer the next count
    useq_incr #(
        .WIDTH(WIDTH)
    ) u_incr (
        .i_value(shaped_addr),
        .i_carry(i_incr_carry_in),
        .o_sum(next_counter),
        .o_carry(o_incr_carry_out)
    );

    // ----------------------------------------------------------------
    // Stack control
    // ----------------------------------------------------------------
    assign do_push = ~i_cmd.stack_cmd_enable_n & i_cmd.push_pop_dir;
    assign do_pop = ~i_cmd.stack_cmd_enable_n & ~i_cmd.push_pop_dir;
    assign next_index = do_push ? PW'(stack_index + 1'b1) :
                        do_pop ? PW'(stack_index - 1'b1) : stack_index;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            sequence_counter <= `USEQ_RESET_VALUE;
            branch_hold_latch <= `USEQ_RESET_VALUE;
            stack_index <= '0;
        end
        else if (i_clk_en)
        begin
            sequence_counter <= next_counter;
            stack_index <= next_index;
            if (!i_hold_latch_load_en_n)
            begin
                branch_hold_latch <= i_hold_latch_inputs;
            end
        end
    end

    // Stack words hold no reset; contents are undefined until pushed
    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && !i_srst && do_push)
        begin
            stack_words[PW'(stack_index + 1'b1)] <= sequence_counter;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    sequence s_push;
        i_clk_en && do_push;
    endsequence

    sequence s_pop;
        i_clk_en && do_pop;
    endsequence

    sequence s_idle_stack;
        i_clk_en && !do_push && !do_pop;
    endsequence

    sequence s_frozen;
        !i_clk_en;
    endsequence

    // Unshaped address: clear inactive and no force-one bits, so the bus shows the raw source
    sequence s_plain_bus;
        i_output_clear_n && i_output_force_one == '0;
    endsequence

    a_push_writes_counter: assert property (s_push |=> stack_top == $past(sequence_counter))
        else $error("push did not store counter on top");
    a_pop_moves_index: assert property (i_clk_en && do_pop |=> stack_index == PW'($past(stack_index) - 1'b1))
        else $error("pop did not step index back");
    a_hold_stack: assert property (i_clk_en && i_cmd.stack_cmd_enable_n |=> $stable(stack_index))
        else $error("stack moved while disabled");
    a_counter_incr: assert property (i_clk_en && i_incr_carry_in |=> sequence_counter == WIDTH'($past(shaped_addr) + 1'b1))
        else $error("counter not address plus one");
    a_counter_same: assert property (i_clk_en && !i_incr_carry_in |=> sequence_counter == $past(shaped_addr))
        else $error("counter not address unchanged");
    a_clear_low: assert property (!i_output_clear_n |-> o_next_addr_bus == '0)
        else $error("clear did not zero bus");
    a_force_one: assert property (i_output_clear_n |-> (o_next_addr_bus & i_output_force_one) == i_output_force_one)
        else $error("force one not applied");
    a_drive_off: assert property (i_output_drive_en_n |-> o_next_addr_bus_oe == '0)
        else $error("bus driven while disabled");
    a_latch_keep: assert property (i_clk_en && i_hold_latch_load_en_n |=> $stable(branch_hold_latch))
        else $error("hold latch changed without load");
    a_select_branch: assert property (i_output_clear_n && i_output_force_one == '0 &&
        i_cmd.source_select == useq_pkg::SRC_BRANCH |-> o_next_addr_bus == i_branch_inputs)
        else $error("branch inputs not presented");

    // ----------------------------------------------------------------
    // Further checks on stack, counter, hold latch, source selection, carry, output control and clock enable
    // ----------------------------------------------------------------
    a_push_index: assert property (s_push
        |=> stack_index == PW'($past(stack_index) + 1'b1))
        else $error("push did not advance index");

    a_idle_index: assert property (s_idle_stack
        |=> $stable(stack_index))
        else $error("index moved without stack command");

    a_freeze_counter: assert property (s_frozen
        |=> $stable(sequence_counter))
        else $error("counter moved while frozen");

    a_freeze_index: assert property (s_frozen
        |=> $stable(stack_index))
        else $error("index moved while frozen");

    a_freeze_latch: assert property (s_frozen
        |=> $stable(branch_hold_latch))
        else $error("hold latch moved while frozen");

    a_latch_load: assert property (i_clk_en && !i_hold_latch_load_en_n
        |=> branch_hold_latch == $past(i_hold_latch_inputs))
        else $error("hold latch did not load");

    a_select_counter: assert property (s_plain_bus ##0
        i_cmd.source_select == useq_pkg::SRC_COUNTER |-> o_next_addr_bus == sequence_counter)
        else $error("counter not presented");

    a_select_hold: assert property (s_plain_bus ##0
        i_cmd.source_select == useq_pkg::SRC_HOLD |-> o_next_addr_bus == branch_hold_latch)
        else $error("hold latch not presented");

    a_select_stack: assert property (s_plain_bus ##0
        i_cmd.source_select == useq_pkg::SRC_STACK |-> o_next_addr_bus == stack_top)
        else $error("stack top not presented");

    // Carry-out must reflect the bus value so an upper slice counts in step
    a_carry_out: assert property (o_incr_carry_out ==
        (i_incr_carry_in && o_next_addr_bus == {WIDTH{1'b1}}))
        else $error("carry out wrong");

    a_drive_on: assert property (!i_output_drive_en_n
        |-> o_next_addr_bus_oe == {WIDTH{1'b1}})
        else $error("bus not driven while enabled");

    a_clear_wins: assert property (!i_output_clear_n && i_output_force_one == {WIDTH{1'b1}}
        |-> o_next_addr_bus == '0)
        else $error("force one beat clear");

    a_force_all: assert property (i_output_clear_n && i_output_force_one == {WIDTH{1'b1}}
        |-> o_next_addr_bus == {WIDTH{1'b1}})
        else $error("force one missed a bit");

    a_ref_keeps_top: assert property (i_clk_en && i_cmd.stack_cmd_enable_n &&
        i_cmd.source_select == useq_pkg::SRC_STACK |=> stack_top == $past(stack_top))
        else $error("stack reference changed top");

    a_ref_counter: assert property (s_plain_bus ##0 i_clk_en && i_incr_carry_in &&
        i_cmd.source_select == useq_pkg::SRC_STACK |=> sequence_counter == WIDTH'($past(stack_top) + 1'b1))
        else $error("counter not top plus one");

    a_branch_counter: assert property (s_plain_bus ##0 i_clk_en && i_incr_carry_in &&
        i_cmd.source_select == useq_pkg::SRC_BRANCH |=> sequence_counter == WIDTH'($past(i_branch_inputs) + 1'b1))
        else $error("counter not branch plus one");

    a_hold_counter: assert property (s_plain_bus ##0 i_clk_en && i_incr_carry_in &&
        i_cmd.source_select == useq_pkg::SRC_HOLD |=> sequence_counter == WIDTH'($past(branch_hold_latch) + 1'b1))
        else $error("counter not latch plus one");
endmodule : useq_sequencer

// *** tb/useq_ctl_mem.sv ***
// Control memory address port model that resolves the three-state address pins
`timescale 1ns/1ps
module useq_ctl_mem (
    input wire logic i_sys_clk,
    input wire logic [3:0] i_addr,
    input wire logic [3:0] i_addr_oe,
    output logic [3:0] o_addr
);
    logic [3:0] last = 4'h0;
    // Released pins show the inverse of the last level so that a stale value never matches
    assign o_addr = (i_addr & i_addr_oe) | (~last & ~i_addr_oe);
    always_ff @(posedge i_sys_clk)
    begin
        last <= o_addr;
    end
endmodule : useq_ctl_mem

// *** tb/useq_sequencer_tb.sv ***
// Self-checking testbench for the sequencer slice
`timescale 1ns/1ps
module useq_sequencer_tb;
    logic i_sys_clk = 0, i_srst = 1, i_clk_en = 1, i_hold_latch_load_en_n = 1;
    logic i_output_clear_n = 1, i_output_drive_en_n = 0, i_incr_carry_in = 1, o_incr_carry_out;
    useq_pkg::seq_cmd_t i_cmd = '{useq_pkg::SRC_COUNTER, 1'b1, 1'b0};
    logic [3:0] i_hold_latch_inputs = 0, i_branch_inputs = 0, i_output_force_one = 0;
    logic [3:0] o_next_addr_bus, o_next_addr_bus_oe, y, j;
    int miscompares = 0, n_compared = 0, cycles = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    useq_sequencer dut (.i_sys_clk, .i_srst, .i_clk_en, .i_cmd, .i_hold_latch_load_en_n,
        .i_hold_latch_inputs, .i_branch_inputs, .i_output_force_one, .i_output_clear_n,
        .i_output_drive_en_n, .i_incr_carry_in, .o_next_addr_bus, .o_next_addr_bus_oe, .o_incr_carry_out);
    useq_ctl_mem mem (.i_sys_clk, .i_addr(o_next_addr_bus), .i_addr_oe(o_next_addr_bus_oe), .o_addr(y));
    task stop_test;
        if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    always @(posedge i_sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 300)
        begin
            miscompares++;
            stop_test();
        end
    end
    task chk(input logic [3:0] e, input logic [3:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    // Apply one microword just after the edge and let the bus settle
    task go(input useq_pkg::source_select_t s, input logic en_n, input logic dir, input logic [3:0] d);
        @(posedge i_sys_clk);
        i_cmd <= '{s, en_n, dir};
        i_branch_inputs <= d;
        #1;
    endtask : go
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_subroutine;
        go(useq_pkg::SRC_COUNTER, 1, 0, 0);
        j = y;
        go(useq_pkg::SRC_COUNTER, 1, 0, 0); chk(j + 4'h1, y);
        go(useq_pkg::SRC_BRANCH, 0, 1, 4'h9); chk(4'h9, y);
        go(useq_pkg::SRC_COUNTER, 1, 0, 0); chk(4'ha, y);
        go(useq_pkg::SRC_STACK, 1, 0, 0); chk(j + 4'h2, y);
        go(useq_pkg::SRC_STACK, 0, 1, 0); chk(j + 4'h2, y);
        go(useq_pkg::SRC_STACK, 0, 0, 0); chk(j + 4'h3, y);
        go(useq_pkg::SRC_STACK, 1, 1, 0); chk(j + 4'h2, y);
        go(useq_pkg::SRC_STACK, 1, 1, 0); chk(j + 4'h2, y);
        go(useq_pkg::SRC_COUNTER, 1, 0, 0); chk(j + 4'h3, y);
    endtask : t_subroutine
    task t_hold;
        i_hold_latch_inputs <= 4'hc;
        i_hold_latch_load_en_n <= 0;
        go(useq_pkg::SRC_COUNTER, 1, 0, 0);
        i_hold_latch_load_en_n <= 1;
        i_hold_latch_inputs <= 4'h2;
        go(useq_pkg::SRC_HOLD, 1, 0, 0); chk(4'hc, y);
        go(useq_pkg::SRC_COUNTER, 1, 0, 0); chk(4'hd, y);
        i_clk_en <= 0;
        go(useq_pkg::SRC_COUNTER, 1, 0, 0); chk(4'hd, y);
        i_clk_en <= 1;
    endtask : t_hold
    task t_outputs;
        go(useq_pkg::SRC_BRANCH, 1, 0, 4'hf); chk(4'h1, {3'h0, o_incr_carry_out});
        i_incr_carry_in <= 0;
        go(useq_pkg::SRC_BRANCH, 1, 0, 4'h6);
        go(useq_pkg::SRC_COUNTER, 1, 0, 0); chk(4'h6, y);
        i_output_force_one <= 4'h9;
        go(useq_pkg::SRC_BRANCH, 1, 0, 4'h2); chk(4'hb, y);
        i_output_clear_n <= 0;
        go(useq_pkg::SRC_BRANCH, 1, 0, 4'h2); chk(4'h0, y);
        i_output_drive_en_n <= 1;
        go(useq_pkg::SRC_BRANCH, 1, 0, 4'h2); chk(4'h0, o_next_addr_bus_oe);
    endtask : t_outputs
    initial
    begin
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 0;
        t_subroutine();
        t_hold();
        t_outputs();
        stop_test();
    end
endmodule : useq_sequencer_tb
